// File: pxs_pkg.sv
// Shared constants, types and register map of the pixel map address and scissor unit
package pxs_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] OFF_POP    = 8'h00;  // Pixel operation register
  localparam logic [7:0] OFF_DIM    = 8'h04;  // Operation dimensions
  localparam logic [7:0] OFF_MOFS   = 8'h08;  // Mask origin offsets
  localparam logic [7:0] OFF_STAT   = 8'h0c;  // Status
  localparam logic [3:0] MAP_BLK0   = 4'h1;   // Map blocks start at 0x10, 0x10 apart
  localparam logic [3:0] MAP_BLKN   = 4'h4;   // Last map block
  localparam logic [1:0] SUB_BASE   = 2'h0;   // Map base pointer word
  localparam logic [1:0] SUB_SIZE   = 2'h1;   // Map width and height word
  localparam logic [1:0] SUB_FMT    = 2'h2;   // Map format word
  localparam logic [7:0] OFF_PTR0   = 8'h50;  // First pointer word, 4 bytes apart
  localparam logic [7:0] OFF_PTR2   = 8'h58;  // Last pointer word

  // Field positions
  localparam int unsigned POP_MODE_LSB = 0;   // Mask mode, two bits
  localparam int unsigned POP_XNEG     = 2;   // X walks to the left
  localparam int unsigned POP_YNEG     = 3;   // Y walks upward
  localparam int unsigned POP_START    = 31;  // Write one to start
  localparam int unsigned HI_LSB       = 16;  // Upper half of a packed pair
  localparam int unsigned STAT_BUSY    = 0;   // Operation running

  // Reset value of every register
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Map indices
  localparam int unsigned MAP_SRC = 0;
  localparam int unsigned MAP_PAT = 1;
  localparam int unsigned MAP_DST = 2;
  localparam int unsigned MAP_MSK = 3;

  // Coordinate space
  localparam int MAP_MAX   = 4096;   // Largest map side in pixels
  localparam int GUARD_PIX = 2048;   // Guardband on every side
  localparam int COORD_MIN = -2048;  // Lowest legal destination coordinate
  localparam int COORD_MAX = 6143;   // Highest legal destination coordinate

  // Mask modes; code 3 is illegal and acts as disabled
  typedef enum logic [1:0] {
    MASK_OFF,
    MASK_BOUND,
    MASK_FULL
  } pxs_mask_mode_t;

  // Memory bit address: byte address plus bit within the byte
  typedef struct packed {
    logic [31:0] byte_addr;
    logic [2:0]  bit_ofs;
  } pxs_addr_t;

  // One pixel step handed to the memory side
  typedef struct packed {
    pxs_addr_t   src;
    pxs_addr_t   pat;
    pxs_addr_t   dst;
    logic        dst_we;
    logic [15:0] dst_x;
    logic [15:0] dst_y;
  } pxs_step_t;

endpackage

// File: pxs_axis_step.sv
// One-axis pointer stepper with optional wrap at the map edge
`timescale 1ns/1ps
module pxs_axis_step #(
  parameter int CW = 16,
  parameter int LW = 12
) (
  input  wire logic [CW-1:0] coord,
  input  wire logic          neg,
  input  wire logic [LW-1:0] lim,
  input  wire logic          wrap,
  output logic      [CW-1:0] nxt
);

  logic [CW-1:0] lim_w;  // Map extent minus one at coordinate width

  assign lim_w = {{(CW-LW){1'b0}}, lim};

  // Source and pattern wrap to the far edge; destination runs free
  always_comb begin
    nxt = coord;
    if (wrap) begin
      if (!neg) begin
        nxt = (coord >= lim_w) ? '0 : coord + 1'b1;
      end else begin
        nxt = (coord == '0 || coord > lim_w) ? lim_w : coord - 1'b1;
      end
    end else begin
      nxt = neg ? coord - 1'b1 : coord + 1'b1;
    end
  end

endmodule

// File: pxs_scissor.sv
// Top of the pixel map address and scissor unit with its Wishbone register file
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - Origin top left, X right, Y down
// - Pixels ascend contiguously from map base
// - Independent source and pattern pointer pairs
// - Source and pattern pointers wrap at edges
// - Destination never wraps, writes suppressed outside
// - Destination coordinates span -2048 to 6143
// - Writes only inside zero to size minus one
// - Destination coordinates are 16-bit two's complement
// - Mask fits destination, placed by origin offsets
// - Mask addressed through destination pointers
// - Three mask modes in operation register
// - Boundary pixels count as inside
// - Disabled mode ignores mask, no mask reads
// - Destination boundary clip in every mode
// - Boundary mode clips to mask rectangle
// - Full mode: mask zero inhibits, one writes
// - Full mode also clips to mask rectangle
// - Mask read as packed one bit pixels
// - Maps up to 4096 by 4096 pixels
module pxs_scissor #(
  parameter int SW = 12  // Width of map size fields
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output pxs_pkg::pxs_step_t     step_o,
  output logic                   step_valid_o,
  input  wire logic              step_ready_i,
  output logic                   mask_req_o,
  output pxs_pkg::pxs_addr_t     mask_addr_o,
  input  wire logic              mask_ack_i,
  input  wire logic              mask_bit_i
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EVAL,
    ST_MWAIT,
    ST_EMIT
  } pxs_state_t;

  // Register file
  logic [31:0]   pop_q,  pop_d;           // Pixel operation register
  logic [31:0]   dim_q,  dim_d;           // Width and height of the walk, minus one
  logic [31:0]   mofs_q, mofs_d;          // Mask origin X low, Y high
  logic [31:0]   base_q [4];              // Map base byte addresses
  logic [31:0]   base_d [4];
  logic [31:0]   size_q [4];              // Map width low, height high, minus one
  logic [31:0]   size_d [4];
  logic [1:0]    fmt_q  [4];              // Log2 of bits per pixel
  logic [1:0]    fmt_d  [4];
  logic          ack_q,  ack_d;           // Bus answer
  logic [31:0]   rdat_q, rdat_d;          // Bus read data

  // Engine state
  pxs_state_t    st_q,   st_d;            // Walk sequencer
  logic [15:0]   px_q   [3];              // X pointers: source, pattern, destination
  logic [15:0]   px_d   [3];
  logic [15:0]   py_q   [3];              // Y pointers
  logic [15:0]   py_d   [3];
  logic [15:0]   rowx_q [3];              // X at the start of the current row
  logic [15:0]   rowx_d [3];
  logic [SW-1:0] cx_q,   cx_d;            // Pixels done in the row
  logic [SW-1:0] cy_q,   cy_d;            // Rows done
  pxs_pkg::pxs_step_t step_q, step_d;     // Step on offer
  logic          sv_q,   sv_d;            // Step valid
  logic          mreq_q, mreq_d;          // Mask read request
  pxs_pkg::pxs_addr_t maddr_q, maddr_d;   // Mask bit address

  // Decode and helpers
  logic          bus_req;                 // New bus cycle this edge
  logic          wr;                      // Write strobe
  logic          busy;                    // Walk in progress
  logic          start;                   // Start request accepted
  logic          in_map;                  // Address falls in a map block
  logic [1:0]    map_i;                   // Map block index
  logic          in_ptr;                  // Address falls on a pointer word
  logic [1:0]    ptr_i;                   // Pointer index
  logic [31:0]   pw;                      // Pointer word merged with the bus write
  logic [15:0]   nx     [3];              // Stepped X pointers
  logic [15:0]   ny     [3];              // Stepped Y pointers
  logic [15:0]   mx, my;                  // Mask pixel coordinate
  logic          in_dst;                  // Destination pointer inside its map
  logic          in_rect;                 // Destination pointer inside mask rectangle
  logic          need_mask;               // Mask contents decide this write
  logic          clip_ok;                 // Write allowed before mask contents
  pxs_pkg::pxs_mask_mode_t mode;          // Mask mode in force

  // Byte lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Bit address of pixel (x,y) in a map, rows ascending from base
  function automatic pxs_pkg::pxs_addr_t bit_addr(input logic [31:0] base,
                                                  input logic [15:0] x,
                                                  input logic [15:0] y,
                                                  input logic [SW-1:0] wm1,
                                                  input logic [1:0] fmt);
    logic [34:0] ofs;
    logic [34:0] sum;
    ofs = 35'(({19'h0, y} * 35'(wm1) + {19'h0, y} + {19'h0, x}) << fmt);
    sum = {base, 3'h0} + ofs;
    return '{byte_addr: sum[34:3], bit_ofs: sum[2:0]};
  endfunction

  // Inside test, both edges inclusive, negative values outside
  function automatic logic in_box(input logic [15:0] c, input logic [SW-1:0] lim);
    return !c[15] && (c <= 16'(lim));
  endfunction

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr      = bus_req && wb_we_i;
  assign busy    = (st_q != ST_IDLE);
  assign start   = wr && wb_adr_i == pxs_pkg::OFF_POP && wb_sel_i[3]
                   && wb_dat_i[pxs_pkg::POP_START] && !busy;
  assign in_map  = wb_adr_i[7:4] >= pxs_pkg::MAP_BLK0 && wb_adr_i[7:4] <= pxs_pkg::MAP_BLKN;
  assign map_i   = 2'(wb_adr_i[7:4] - pxs_pkg::MAP_BLK0);
  assign in_ptr  = wb_adr_i >= pxs_pkg::OFF_PTR0 && wb_adr_i <= pxs_pkg::OFF_PTR2
                   && wb_adr_i[1:0] == 2'h0;
  assign ptr_i   = wb_adr_i[3:2] - pxs_pkg::OFF_PTR0[3:2];
  assign pw      = merge({py_q[ptr_i], px_q[ptr_i]}, wb_dat_i, wb_sel_i);

  // Illegal mode code behaves as disabled
  always_comb begin
    unique case (pop_q[pxs_pkg::POP_MODE_LSB +: 2])
      2'h1:    mode = pxs_pkg::MASK_BOUND;
      2'h2:    mode = pxs_pkg::MASK_FULL;
      default: mode = pxs_pkg::MASK_OFF;
    endcase
  end

  // 16-bit guardband span
  // Per-axis steppers; source and pattern wrap, destination does not
  for (genvar m = 0; m < 3; m++) begin : g_step
    pxs_axis_step #(.CW(16), .LW(SW)) u_x (
      .coord (px_q[m]),
      .neg   (pop_q[pxs_pkg::POP_XNEG]),
      .lim   (size_q[m][SW-1:0]),
      .wrap  (m != pxs_pkg::MAP_DST),
      .nxt   (nx[m])
    );
    pxs_axis_step #(.CW(16), .LW(SW)) u_y (
      .coord (py_q[m]),
      .neg   (pop_q[pxs_pkg::POP_YNEG]),
      .lim   (size_q[m][pxs_pkg::HI_LSB +: SW]),
      .wrap  (m != pxs_pkg::MAP_DST),
      .nxt   (ny[m])
    );
  end

  // Clip decisions for the current destination pointer
  always_comb begin
    mx = px_q[pxs_pkg::MAP_DST] - mofs_q[15:0];
    my = py_q[pxs_pkg::MAP_DST] - mofs_q[31:16];
    in_dst = in_box(px_q[pxs_pkg::MAP_DST], size_q[pxs_pkg::MAP_DST][SW-1:0])
             && in_box(py_q[pxs_pkg::MAP_DST], size_q[pxs_pkg::MAP_DST][pxs_pkg::HI_LSB +: SW]);
    in_rect = in_box(mx, size_q[pxs_pkg::MAP_MSK][SW-1:0])
              && in_box(my, size_q[pxs_pkg::MAP_MSK][pxs_pkg::HI_LSB +: SW]);
    clip_ok = in_dst;
    if (mode != pxs_pkg::MASK_OFF) begin
      clip_ok = clip_ok && in_rect;
    end
    need_mask = clip_ok && (mode == pxs_pkg::MASK_FULL);
  end

  // Register file next values and bus answer
  always_comb begin
    pop_d  = pop_q;
    dim_d  = dim_q;
    mofs_d = mofs_q;
    base_d = base_q;
    size_d = size_q;
    fmt_d  = fmt_q;
    ack_d  = bus_req;
    rdat_d = rdat_q;
    // Configuration writes are ignored while a walk runs
    if (wr && !busy) begin
      if (wb_adr_i == pxs_pkg::OFF_POP) begin
        pop_d = merge(pop_q, wb_dat_i, wb_sel_i) & 32'h0000_000f;
      end else if (wb_adr_i == pxs_pkg::OFF_DIM) begin
        dim_d = merge(dim_q, wb_dat_i, wb_sel_i) & 32'h0fff_0fff;
      end else if (wb_adr_i == pxs_pkg::OFF_MOFS) begin
        mofs_d = merge(mofs_q, wb_dat_i, wb_sel_i);
      end else if (in_map && wb_adr_i[3:2] == pxs_pkg::SUB_BASE) begin
        base_d[map_i] = merge(base_q[map_i], wb_dat_i, wb_sel_i);
      end else if (in_map && wb_adr_i[3:2] == pxs_pkg::SUB_SIZE) begin
        size_d[map_i] = merge(size_q[map_i], wb_dat_i, wb_sel_i) & 32'h0fff_0fff;
      end else if (in_map && wb_adr_i[3:2] == pxs_pkg::SUB_FMT && wb_sel_i[0]) begin
        fmt_d[map_i] = wb_dat_i[1:0];
      end
    end
    // Read mux; unmapped addresses read zero
    if (bus_req) begin
      rdat_d = 32'h0000_0000;
      if (wb_adr_i == pxs_pkg::OFF_POP) begin
        rdat_d = pop_q;
      end else if (wb_adr_i == pxs_pkg::OFF_DIM) begin
        rdat_d = dim_q;
      end else if (wb_adr_i == pxs_pkg::OFF_MOFS) begin
        rdat_d = mofs_q;
      end else if (wb_adr_i == pxs_pkg::OFF_STAT) begin
        rdat_d[pxs_pkg::STAT_BUSY] = busy;
      end else if (in_map && wb_adr_i[3:2] == pxs_pkg::SUB_BASE) begin
        rdat_d = base_q[map_i];
      end else if (in_map && wb_adr_i[3:2] == pxs_pkg::SUB_SIZE) begin
        rdat_d = size_q[map_i];
      end else if (in_map && wb_adr_i[3:2] == pxs_pkg::SUB_FMT) begin
        rdat_d = {30'h0, fmt_q[map_i]};
      end else if (in_ptr) begin
        rdat_d = {py_q[ptr_i], px_q[ptr_i]};
      end
    end
  end

  // Register file storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pop_q  <= pxs_pkg::RST_WORD;
      dim_q  <= pxs_pkg::RST_WORD;
      mofs_q <= pxs_pkg::RST_WORD;
      for (int i = 0; i < 4; i++) begin
        base_q[i] <= pxs_pkg::RST_WORD;
        size_q[i] <= pxs_pkg::RST_WORD;
        fmt_q[i]  <= 2'h0;
      end
      ack_q  <= 1'b0;
      rdat_q <= pxs_pkg::RST_WORD;
    end else begin
      pop_q  <= pop_d;
      dim_q  <= dim_d;
      mofs_q <= mofs_d;
      base_q <= base_d;
      size_q <= size_d;
      fmt_q  <= fmt_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // Walk sequencer and pointer next values
  always_comb begin
    st_d    = st_q;
    px_d    = px_q;
    py_d    = py_q;
    rowx_d  = rowx_q;
    cx_d    = cx_q;
    cy_d    = cy_q;
    step_d  = step_q;
    sv_d    = sv_q;
    mreq_d  = mreq_q;
    maddr_d = maddr_q;
    unique case (st_q)
      ST_IDLE: begin
        // Pointer loads only while idle
        if (wr && in_ptr && ptr_i != 2'h3) begin
          px_d[ptr_i]   = pw[15:0];
          py_d[ptr_i]   = pw[31:16];
          rowx_d[ptr_i] = px_d[ptr_i];
        end
        if (start) begin
          cx_d = '0;
          cy_d = '0;
          st_d = ST_EVAL;
        end
      end
      ST_EVAL: begin
        step_d.src   = bit_addr(base_q[pxs_pkg::MAP_SRC], px_q[pxs_pkg::MAP_SRC],
                                py_q[pxs_pkg::MAP_SRC], size_q[pxs_pkg::MAP_SRC][SW-1:0],
                                fmt_q[pxs_pkg::MAP_SRC]);
        step_d.pat   = bit_addr(base_q[pxs_pkg::MAP_PAT], px_q[pxs_pkg::MAP_PAT],
                                py_q[pxs_pkg::MAP_PAT], size_q[pxs_pkg::MAP_PAT][SW-1:0],
                                2'h0);
        step_d.dst   = bit_addr(base_q[pxs_pkg::MAP_DST], px_q[pxs_pkg::MAP_DST],
                                py_q[pxs_pkg::MAP_DST], size_q[pxs_pkg::MAP_DST][SW-1:0],
                                fmt_q[pxs_pkg::MAP_DST]);
        step_d.dst_x = px_q[pxs_pkg::MAP_DST];
        step_d.dst_y = py_q[pxs_pkg::MAP_DST];
        step_d.dst_we = clip_ok;
        if (need_mask) begin
          maddr_d = bit_addr(base_q[pxs_pkg::MAP_MSK], mx, my,
                             size_q[pxs_pkg::MAP_MSK][SW-1:0], 2'h0);
          mreq_d  = 1'b1;
          st_d    = ST_MWAIT;
        end else begin
          sv_d = 1'b1;
          st_d = ST_EMIT;
        end
      end
      ST_MWAIT: begin
        if (mask_ack_i) begin
          step_d.dst_we = step_q.dst_we && mask_bit_i;
          mreq_d = 1'b0;
          sv_d   = 1'b1;
          st_d   = ST_EMIT;
        end
      end
      ST_EMIT: begin
        if (step_ready_i) begin
          sv_d = 1'b0;
          st_d = ST_EVAL;
          if (cx_q != dim_q[SW-1:0]) begin
            cx_d = cx_q + 1'b1;
            px_d = nx;
          end else if (cy_q != dim_q[pxs_pkg::HI_LSB +: SW]) begin
            cx_d   = '0;
            cy_d   = cy_q + 1'b1;
            px_d   = rowx_q;
            py_d   = ny;
          end else begin
            // Leave pointers on the last pixel and ready the next start
            rowx_d = px_q;
            st_d   = ST_IDLE;
          end
        end
      end
    endcase
  end

  // Walk state storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q    <= ST_IDLE;
      for (int i = 0; i < 3; i++) begin
        px_q[i]   <= 16'h0000;
        py_q[i]   <= 16'h0000;
        rowx_q[i] <= 16'h0000;
      end
      cx_q    <= '0;
      cy_q    <= '0;
      step_q  <= '0;
      sv_q    <= 1'b0;
      mreq_q  <= 1'b0;
      maddr_q <= '0;
    end else begin
      st_q    <= st_d;
      px_q    <= px_d;
      py_q    <= py_d;
      rowx_q  <= rowx_d;
      cx_q    <= cx_d;
      cy_q    <= cy_d;
      step_q  <= step_d;
      sv_q    <= sv_d;
      mreq_q  <= mreq_d;
      maddr_q <= maddr_d;
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = rdat_q;
  assign step_o       = step_q;
  assign step_valid_o = sv_q;
  assign mask_req_o   = mreq_q;
  assign mask_addr_o  = maddr_q;

endmodule

// File: pxs_monitor.sv
// Port checker for the pixel scissor unit
`timescale 1ns/1ps
module pxs_monitor #(
  parameter int SW = 12  // Map size field width
) (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [7:0]         wb_adr_i,
  input wire logic [3:0]         wb_sel_i,
  input wire logic [31:0]        wb_dat_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire pxs_pkg::pxs_step_t step_o,
  input wire logic               step_valid_o,
  input wire logic               step_ready_i,
  input wire logic               mask_req_o,
  input wire pxs_pkg::pxs_addr_t mask_addr_o,
  input wire logic               mask_ack_i,
  input wire logic               mask_bit_i
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);
  // Bus request taken by the slave
  sequence s_bus_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Mask bit handed over by memory
  sequence s_mask_taken;
    mask_req_o && mask_ack_i;
  endsequence
  AST_ACK_PULSE: assert property (s_bus_taken |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer is not a one cycle pulse");
  AST_STEP_HOLD: assert property (
    step_valid_o && !step_ready_i |=> step_valid_o && $stable(step_o))
    else $error("step changed before acceptance");
  AST_STEP_GAP: assert property (step_valid_o && step_ready_i |=> !step_valid_o)
    else $error("next step too soon");
  AST_MREQ_HOLD: assert property (
    mask_req_o && !mask_ack_i |=> mask_req_o && $stable(mask_addr_o))
    else $error("mask request changed before answer");
  AST_MASK_WE: assert property (
    s_mask_taken |=> !mask_req_o && step_valid_o && step_o.dst_we == $past(mask_bit_i))
    else $error("write enable does not follow mask bit");
  AST_WE_NONNEG: assert property (
    step_valid_o && step_o.dst_we |-> !step_o.dst_x[15] && !step_o.dst_y[15])
    else $error("write enabled at negative coordinate");
  AST_MASK_IN_DST: assert property (
    s_mask_taken |=> !step_o.dst_x[15] && !step_o.dst_y[15])
    else $error("mask read for pixel outside destination");
  AST_NO_STEP_WAIT: assert property (mask_req_o |-> !step_valid_o)
    else $error("step issued while mask bit pending");
endmodule

// File: pxs_mem_model.sv
// Memory side model: takes pixel steps and serves mask bits
`timescale 1ns/1ps
module pxs_mem_model (
  input  wire logic               clk,
  input  wire logic               nrst,
  output logic                    step_ready,
  input  wire logic               mask_req,
  input  wire pxs_pkg::pxs_addr_t mask_addr,
  output logic                    mask_ack,
  output logic                    mask_bit
);
  // Random stalls on both ports, one mask read at a time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      step_ready <= 1'b0;
      mask_ack   <= 1'b0;
      mask_bit   <= 1'b0;
    end else begin
      step_ready <= ($urandom % 3) != 0;
      // mask bit of a pixel from its address: bit_ofs[0] xor byte_addr[0]
      if (mask_req && !mask_ack && ($urandom % 2) == 0) begin
        mask_ack <= 1'b1;
        mask_bit <= mask_addr.bit_ofs[0] ^ mask_addr.byte_addr[0];
      end else begin
        mask_ack <= 1'b0;
        mask_bit <= ~mask_bit;  // Released line shows no stale value
      end
    end
  end
endmodule

// File: test_pxs_scissor.sv
// Self-checking bench for the pixel scissor unit
`timescale 1ns/1ps
module test_pxs_scissor;
  localparam int SW = 12;          // Map size field width
  logic               clk, nrst;   // Clock and reset
  logic               cyc, stb, we, ack;
  logic [7:0]         adr;         // Bus address
  logic [3:0]         sel;         // Byte enables
  logic [31:0]        wdat, rdat, rd;
  logic               rdy, svalid, mreq, mack, mbit;
  pxs_pkg::pxs_step_t step, e;     // Observed and expected step
  pxs_pkg::pxs_addr_t maddr;       // Mask bit address
  pxs_pkg::pxs_step_t qe[$];       // Expected steps in order
  int                 failures, check_count;
  int                 mreads;      // Mask reads seen in this operation

  pxs_scissor #(.SW(SW)) dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .step_o(step), .step_valid_o(svalid), .step_ready_i(rdy),
    .mask_req_o(mreq), .mask_addr_o(maddr), .mask_ack_i(mack), .mask_bit_i(mbit));
  pxs_mem_model mem (.clk(clk), .nrst(nrst), .step_ready(rdy), .mask_req(mreq),
    .mask_addr(maddr), .mask_ack(mack), .mask_bit(mbit));

  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Verdict and end of run
  task automatic summarize();
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Compare one word and report a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  // One classic bus cycle, held until ack is seen
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Wrapped coordinate within a map of n pixels
  function automatic int wrp(input int p, input int d, input int n);
    return ((p + d) % n + n) % n;
  endfunction
  // Bit address of a pixel
  function automatic logic [34:0] ba(input logic [31:0] b, input int x, input int y,
                                     input int w, input int f);
    return {b, 3'h0} + 35'((longint'(y) * (w + 1) + x) << f);
  endfunction
  // Each accepted step against the model
  always @(posedge clk) begin
    // Count mask bits handed over
    if (nrst && mreq === 1'b1 && mack === 1'b1) begin
      mreads++;
    end
    if (nrst && svalid === 1'b1 && rdy === 1'b1) begin
      e = qe.size() ? qe.pop_front() : '0;
      check_count++;
      if ({step.src, step.pat, step.dst_we, step.dst_x, step.dst_y} !==
          {e.src, e.pat, e.dst_we, e.dst_x, e.dst_y} || (e.dst_we && step.dst !== e.dst)) begin
        failures++;
        $display("[FAIL] %0t step mismatch", $time);
      end
    end
  end
  // One block operation in mask mode m with random maps
  task automatic run_op(input int m);
    int W[4], H[4], X[3], Y[3], w, h, f, xn, yn, i, j, k, x, y, ok, nm;
    logic [31:0] B[4];
    pxs_pkg::pxs_step_t s;
    logic [34:0] a;
    mreads = 0;
    nm = 0;
    w = 1 + $urandom % 5;
    h = $urandom % 4;
    f = $urandom % 4;
    xn = $urandom % 2;
    yn = $urandom % 2;
    for (k = 0; k < 4; k++) begin
      W[k] = $urandom % 4 + (k == 2 ? 4 : 0);
      H[k] = $urandom % 4 + (k == 2 ? 4 : 0);
      B[k] = $urandom;
      rw(1'b1, 8'(16 * k + 16), B[k]);
      rw(1'b1, 8'(16 * k + 20), {4'h0, 12'(H[k]), 4'h0, 12'(W[k])});
      rw(1'b1, 8'(16 * k + 24), 32'(f));
    end
    // destination start stays near the map
    for (k = 0; k < 3; k++) begin
      X[k] = k == 2 ? $urandom % 9 - 3 : $urandom % (W[k] + 1);
      Y[k] = k == 2 ? $urandom % 9 - 3 : $urandom % (H[k] + 1);
      rw(1'b1, 8'(4 * k + 80), {16'(Y[k]), 16'(X[k])});
    end
    rw(1'b1, pxs_pkg::OFF_DIM, {4'h0, 12'(h), 4'h0, 12'(w)});
    rw(1'b1, pxs_pkg::OFF_MOFS, 32'h0001_0002);
    for (j = 0; j <= h; j++) begin
      for (i = 0; i <= w; i++) begin
        s.src = ba(B[0], wrp(X[0], (1 - 2 * xn) * i, W[0] + 1),
                   wrp(Y[0], (1 - 2 * yn) * j, H[0] + 1), W[0], f);
        s.pat = ba(B[1], wrp(X[1], (1 - 2 * xn) * i, W[1] + 1),
                   wrp(Y[1], (1 - 2 * yn) * j, H[1] + 1), W[1], 0);
        x = X[2] + (1 - 2 * xn) * i;
        y = Y[2] + (1 - 2 * yn) * j;
        s.dst = ba(B[2], x, y, W[2], f);
        ok = x >= 0 && x <= W[2] && y >= 0 && y <= H[2];
        if (m == 1 || m == 2) ok = ok && x >= 2 && x - 2 <= W[3] && y >= 1 && y - 1 <= H[3];
        a = ba(B[3], x - 2, y - 1, W[3], 0);
        nm += (m == 2 && ok);
        if (m == 2 && ok) ok = a[0] ^ a[3];
        s.dst_we = 1'(ok);
        s.dst_x = 16'(x);
        s.dst_y = 16'(y);
        qe.push_back(s);
      end
    end
    rw(1'b1, pxs_pkg::OFF_POP, 32'h8000_0000 | 32'(m + 4 * xn + 8 * yn));
    rw(1'b1, pxs_pkg::OFF_MOFS, 32'hffff_ffff);
    do rw(1'b0, pxs_pkg::OFF_STAT, 32'h0); while (rd[0] !== 1'b0);
    chk(32'(qe.size()), 32'h0, "steps missing");
    chk(32'(mreads), 32'(nm), "mask read count");
    rw(1'b0, pxs_pkg::OFF_MOFS, 32'h0);
    chk(rd, 32'h0001_0002, "write while busy took effect");
    rw(1'b0, 8'h58, 32'h0);
    chk(rd, {16'(y), 16'(x)}, "destination pointer wrapped");
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    failures = 0;
    check_count = 0;
    void'($urandom(49));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rw(1'b0, pxs_pkg::OFF_POP, 32'h0);
    chk(rd, pxs_pkg::RST_WORD, "operation register reset");
    rw(1'b0, 8'hfc, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    for (int k = 0; k < 8; k++) run_op(k % 4);
    summarize();
  end
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
bind pxs_scissor pxs_monitor #(.SW(SW)) u_mon (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .step_o(step_o),
  .step_valid_o(step_valid_o), .step_ready_i(step_ready_i), .mask_req_o(mask_req_o),
  .mask_addr_o(mask_addr_o), .mask_ack_i(mask_ack_i), .mask_bit_i(mask_bit_i));
